// *** core/scos_pkg.sv ***
// Package of constants, selection codes and decode functions for sync/clock output select
package scos_pkg;

  // ----------------------------------------------------------------
  // Selection codes for the sync output
  // ----------------------------------------------------------------
  typedef enum logic [4:0]
  {
    SEL_G1_D1, SEL_G1_D2, SEL_G1_D4, SEL_G1_D8, SEL_G1_D16, SEL_G1_D64, SEL_G1_PAT,
    SEL_G2_D1, SEL_G2_D2, SEL_G2_D4, SEL_G2_D8, SEL_G2_D16, SEL_G2_D64, SEL_G2_PAT,
    SEL_E1_D4, SEL_E1_D8, SEL_E1_D16,
    SEL_E2_D4, SEL_E2_D8, SEL_E2_D16
  } scos_sel_t;

  // Channel divide rate codes: 1/1 up to 1/64
  typedef enum logic [2:0]
  {
    DIV_1, DIV_2, DIV_4, DIV_8, DIV_16, DIV_32, DIV_64
  } scos_div_t;

  // Reference clock modes
  typedef enum logic [1:0]
  {
    REF_INTERNAL, REF_EXT_10M, REF_EXT_SIXTEENTH
  } scos_ref_t;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam scos_sel_t   SEL_RST        = SEL_G1_PAT;
  localparam int          SEL_W          = 5;
  localparam int          LEN_W          = 32;
  localparam int          FREQ_W         = 40;
  localparam logic [2:0]  FCLK_MAX_DIV   = 3'h3;
  localparam logic [4:0]  EXT_MULT_SHIFT = 5'h4;
  localparam logic [LEN_W-1:0] RATIO_1   = 32'h0000_0001;
  localparam logic [LEN_W-1:0] RATIO_2   = 32'h0000_0002;
  localparam logic [LEN_W-1:0] RATIO_4   = 32'h0000_0004;
  localparam logic [LEN_W-1:0] RATIO_8   = 32'h0000_0008;
  localparam logic [LEN_W-1:0] RATIO_16  = 32'h0000_0010;
  localparam logic [LEN_W-1:0] RATIO_64  = 32'h0000_0040;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic sel_is_pat(input scos_sel_t s);
    return (s == SEL_G1_PAT) || (s == SEL_G2_PAT);
  endfunction

  function automatic logic sel_is_det(input scos_sel_t s);
    return s >= SEL_E1_D4;
  endfunction

  // Channel 2 sources
  function automatic logic sel_is_ch2(input scos_sel_t s);
    return ((s >= SEL_G2_D1) && (s <= SEL_G2_PAT)) || (s >= SEL_E2_D4);
  endfunction

  // Fixed ratio; pattern sync takes the pattern length instead
  function automatic logic [LEN_W-1:0] sel_ratio(input scos_sel_t s);
    unique case (s)
      SEL_G1_D1, SEL_G2_D1:                                     return RATIO_1;
      SEL_G1_D2, SEL_G2_D2:                                     return RATIO_2;
      SEL_G1_D4, SEL_G2_D4, SEL_E1_D4, SEL_E2_D4:               return RATIO_4;
      SEL_G1_D8, SEL_G2_D8, SEL_E1_D8, SEL_E2_D8:               return RATIO_8;
      SEL_G1_D16, SEL_G2_D16, SEL_E1_D16, SEL_E2_D16:           return RATIO_16;
      SEL_G1_D64, SEL_G2_D64:                                   return RATIO_64;
      default:                                                  return RATIO_1;
    endcase
  endfunction

  // Legal combination of selection and the source channel's divide rate
  function automatic logic sel_legal(input logic [SEL_W-1:0] code,
                                     input scos_div_t        div,
                                     input logic             pat_blocked);
    scos_sel_t   s;
    logic [LEN_W-1:0] r;
    s = scos_sel_t'(code);
    r = sel_ratio(s);
    if (code > SEL_W'(SEL_E2_D16))
      return 1'b0;
    if (sel_is_pat(s))
      return !pat_blocked;
    if (sel_is_det(s))
    begin
      unique case (div)
        DIV_1:   return (r == RATIO_8) || (r == RATIO_16);
        DIV_2:   return (r == RATIO_4) || (r == RATIO_16);
        default: return 1'b0;
      endcase
    end
    unique case (div)
      DIV_1:   return (r == RATIO_8) || (r == RATIO_16) || (r == RATIO_64);
      DIV_2:   return (r == RATIO_4) || (r == RATIO_16);
      DIV_4:   return (r == RATIO_2) || (r == RATIO_16);
      default: return r == RATIO_1;
    endcase
  endfunction

endpackage

// *** core/scos_strobe_div.sv ***
// Strobe divider: one tick for every N source bit strobes
`timescale 1ns/1ns
`default_nettype none

module scos_strobe_div
  import scos_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             restart,
  input  wire logic             bit_stb,
  input  wire logic [LEN_W-1:0] ratio,
  output logic                  tick
);

  logic [LEN_W-1:0] cnt_q;
  logic [LEN_W-1:0] cnt_d;
  logic             tick_q;
  logic             tick_d;
  logic [LEN_W-1:0] last;

  // A ratio of zero behaves as one so the counter can never run away
  always_comb
  begin
    last   = (ratio == '0) ? '0 : ratio - RATIO_1;
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (restart)
      cnt_d = '0;
    else if (bit_stb)
    begin
      if (cnt_q >= last)
      begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end
      else
        cnt_d = cnt_q + RATIO_1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// *** core/scos_top.sv ***
// Sync output and full-rate clock output source/divide selection
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Each sync selection picks generator 1, generator 2, detector 1 or detector 2 and a fixed ratio or the pattern length.
// - At generator divide 1/1 only 8, 16, 64 and pattern sync are legal; at 1/2 only 4, 16, pattern.
// - At generator divide 1/4 only 2, 16 and pattern are legal; at 1/8 and slower only 1 and pattern.
// - Detector sync at detector 1/1 allows only 8 and 16; at 1/2 only 4 and 16.
// - Channel 2 keeps the same combination limits using its own generator and detector.
// - The full-rate clock runs only at generator divide 1/1, 1/2, 1/4 or 1/8.
// - Writing the sync selection also sets the full-rate clock source.
// - The full-rate clock stays on while a generator pattern sync is selected.
// - With the 10 MHz reference the full-rate frequency is the bit rate scaled by the divide.
// - With a sixteenth-rate reference the frequency is sixteen times the input, scaled by divide.
// - On the base model pattern sync is blocked while scope data-clock tracking is on.
module scos_top
  import scos_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  input  wire logic               sel_wr,
  input  wire logic [SEL_W-1:0]   sel_code,
  input  wire scos_div_t          gen1_div,
  input  wire scos_div_t          gen2_div,
  input  wire scos_div_t          det1_div,
  input  wire scos_div_t          det2_div,
  input  wire logic               gen1_bit_stb,
  input  wire logic               gen2_bit_stb,
  input  wire logic               det1_bit_stb,
  input  wire logic               det2_bit_stb,
  input  wire logic [LEN_W-1:0]   gen1_pat_len,
  input  wire logic [LEN_W-1:0]   gen2_pat_len,
  input  wire logic               base_model,
  input  wire logic               scope_track_on,
  input  wire scos_ref_t          ref_mode,
  input  wire logic [LEN_W-1:0]   bit_rate_khz,
  input  wire logic [LEN_W-1:0]   ext_in_khz,
  output scos_sel_t               sel_cur,
  output logic                    sel_err,
  output logic                    sync_out,
  output logic                    sync_active,
  output logic                    full_clk_out,
  output logic                    full_clk_en,
  output logic [FREQ_W-1:0]       full_freq_khz
);

  // ----------------------------------------------------------------
  // Legality of the incoming write
  // ----------------------------------------------------------------
  function automatic scos_div_t src_div(input scos_sel_t s, input logic gen_side);
    if (sel_is_det(s) && !gen_side)
      return sel_is_ch2(s) ? det2_div : det1_div;
    return sel_is_ch2(s) ? gen2_div : gen1_div;
  endfunction

  logic      pat_blocked;
  scos_sel_t wr_sel;
  logic      wr_legal;

  // Procedural on purpose: src_div reads the divide ports, which a continuous assign would miss
  always_comb
  begin
    pat_blocked = base_model && scope_track_on;
    wr_sel      = scos_sel_t'(sel_code);
    wr_legal    = sel_legal(sel_code, src_div(wr_sel, 1'b0), pat_blocked);
  end

  // ----------------------------------------------------------------
  // Selection register
  // ----------------------------------------------------------------
  scos_sel_t sel_q;
  scos_sel_t sel_d;
  logic      err_q;
  logic      err_d;
  logic      restart;

  // one write picks both sync and full-rate source; refused writes keep the old choice
  always_comb
  begin
    sel_d   = sel_q;
    err_d   = 1'b0;
    restart = 1'b0;
    if (sel_wr)
    begin
      if (wr_legal)
      begin
        sel_d   = wr_sel;
        restart = 1'b1;
      end
      else
        err_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sel_q <= SEL_RST;
      err_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sel_q <= sel_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and sync divider
  // ----------------------------------------------------------------
  logic             src_stb;
  logic [LEN_W-1:0] div_ratio;
  logic             sel_ok;
  logic             fclk_ok;
  logic             tick;
  scos_div_t        gdiv;

  // A later divide change can make a held selection illegal; output is then gated, not rewritten
  always_comb
  begin
    sel_ok = sel_legal(sel_q, src_div(sel_q, 1'b0), pat_blocked);
    gdiv   = src_div(sel_q, 1'b1);
  end

  always_comb
  begin
    unique case ({sel_is_det(sel_q), sel_is_ch2(sel_q)})
      2'b00: src_stb = gen1_bit_stb;
      2'b01: src_stb = gen2_bit_stb;
      2'b10: src_stb = det1_bit_stb;
      2'b11: src_stb = det2_bit_stb;
    endcase
    // pattern length sets the pattern sync period
    if (sel_q == SEL_G1_PAT)
      div_ratio = gen1_pat_len;
    else if (sel_q == SEL_G2_PAT)
      div_ratio = gen2_pat_len;
    else
      div_ratio = sel_ratio(sel_q);
  end

  scos_strobe_div u_div
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .restart  (restart),
    .bit_stb  (src_stb),
    .ratio    (div_ratio),
    .tick     (tick)
  );

  // full-rate clock depends only on the generator divide, pattern sync included
  assign fclk_ok = (gdiv <= scos_div_t'(FCLK_MAX_DIV));

  // ----------------------------------------------------------------
  // Output registers and frequency
  // ----------------------------------------------------------------
  logic              sync_q;
  logic              sync_d;
  logic              act_q;
  logic              fclk_q;
  logic              fclk_d;
  logic              fen_q;
  logic [FREQ_W-1:0] freq_q;
  logic [FREQ_W-1:0] freq_d;
  logic [FREQ_W-1:0] base_freq;

  always_comb
  begin
    sync_d = tick && sel_ok;
    fclk_d = src_stb && fclk_ok;
    // bit rate or sixteen times the input, scaled by the divide denominator
    if (ref_mode == REF_EXT_SIXTEENTH)
      base_freq = FREQ_W'(ext_in_khz) << EXT_MULT_SHIFT;
    else
      base_freq = FREQ_W'(bit_rate_khz);
    freq_d = fclk_ok ? (base_freq << gdiv) : '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync_q <= 1'b0;
      act_q  <= 1'b0;
      fclk_q <= 1'b0;
      fen_q  <= 1'b0;
      freq_q <= '0;
    end
    else if (clk_en)
    begin
      sync_q <= sync_d;
      act_q  <= sel_ok;
      fclk_q <= fclk_d;
      fen_q  <= fclk_ok;
      freq_q <= freq_d;
    end
  end

  assign sel_cur       = sel_q;
  assign sel_err       = err_q;
  assign sync_out      = sync_q;
  assign sync_active   = act_q;
  assign full_clk_out  = fclk_q;
  assign full_clk_en   = fen_q;
  assign full_freq_khz = freq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_illegal_refused: assert property (clk_en && sel_wr && !wr_legal |=> sel_err && $stable(sel_q))
    else $error("Illegal selection was not refused");
  a_write_taken: assert property (clk_en && sel_wr && wr_legal |=> sel_q == $past(wr_sel))
    else $error("Legal selection was not taken");
  a_slow_div_only1: assert property (clk_en && sel_wr && sel_code == SEL_W'(SEL_G1_D8)
                                     && gen1_div >= DIV_8 |=> sel_err)
    else $error("Divide-by-8 accepted at slow generator divide");
  a_det_slow_refused: assert property (clk_en && sel_wr && sel_code == SEL_W'(SEL_E1_D8)
                                       && det1_div > DIV_2 |=> sel_err)
    else $error("Detector selection accepted at slow divide");
  a_ch2_same_limits: assert property (clk_en && sel_wr && sel_code == SEL_W'(SEL_G2_D1)
                                      && gen2_div == DIV_1 |=> sel_err)
    else $error("Channel 2 divide-by-1 accepted at divide 1/1");
  a_fclk_slow_off: assert property (clk_en && gdiv >= DIV_16 |=> !full_clk_en && !full_clk_out
                                    && full_freq_khz == '0)
    else $error("Full-rate clock active at slow divide");
  a_fclk_on_pattern: assert property (clk_en && sel_is_pat(sel_q) && gdiv <= DIV_8
                                      |=> full_clk_en)
    else $error("Full-rate clock dropped under pattern sync");
  a_freq_ext10: assert property (clk_en && ref_mode == REF_EXT_10M && gdiv == DIV_8
                                 |=> full_freq_khz == FREQ_W'($past(bit_rate_khz)) * 8)
    else $error("Full-rate frequency wrong for 10 MHz reference");
  a_freq_sixteenth: assert property (clk_en && ref_mode == REF_EXT_SIXTEENTH && gdiv == DIV_1
                                     |=> full_freq_khz == FREQ_W'($past(ext_in_khz)) * 16)
    else $error("Full-rate frequency wrong for sixteenth-rate reference");
  a_pat_blocked: assert property (clk_en && sel_wr && pat_blocked
                                  && sel_code == SEL_W'(SEL_G2_PAT) |=> sel_err)
    else $error("Pattern sync accepted while tracking lock active");
  a_sync_legal: assert property (sync_out |-> $past(sel_ok, 1))
    else $error("Sync pulse from an illegal selection");

  c_pattern_pulse: cover property (sel_q == SEL_G1_PAT ##1 sync_out);
  c_det_pulse:     cover property (sel_is_det(sel_q) && sync_out);
  c_refused:       cover property (sel_err);
  c_fclk_run:      cover property (full_clk_en && full_clk_out);

endmodule
`default_nettype wire

// *** sim/scos_scope_sink.sv ***
// Far-side model: trigger input that times sync pulses and counts full-rate clock pulses
`timescale 1ns/1ns
`default_nettype none

module scos_scope_sink
(
  input  wire logic        core_clk,
  input  wire logic        clr,
  input  wire logic        sync_out,
  input  wire logic        full_clk_out,
  output logic [15:0]      sync_per,
  output logic [15:0]      sync_cnt,
  output logic [15:0]      fclk_cnt
);
  logic [15:0] since_q;

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  // A trigger input only listens; the first period after a source change is junk
  always_ff @(posedge core_clk)
  begin
    since_q <= sync_out ? 16'h0001 : since_q + 16'h0001;
    if (sync_out)
      sync_per <= since_q;
    if (clr)
    begin
      sync_cnt <= 16'h0000;
      fclk_cnt <= 16'h0000;
    end
    else
    begin
      sync_cnt <= sync_cnt + 16'(sync_out);
      fclk_cnt <= fclk_cnt + 16'(full_clk_out);
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Testbench for sync/clock output select: legality, sync periods, full-rate clock
`timescale 1ns/1ns
`default_nettype none

module tb;
  import scos_pkg::*;

  logic              core_clk       = 1'b0;
  logic              rst_n          = 1'b0;
  logic              clk_en         = 1'b1;
  logic              sel_wr         = 1'b0;
  logic [SEL_W-1:0]  sel_code       = 5'h00;
  scos_div_t         gen1_div       = DIV_1;
  scos_div_t         gen2_div       = DIV_1;
  scos_div_t         det1_div       = DIV_1;
  scos_div_t         det2_div       = DIV_1;
  logic [3:0]        stb            = 4'h0;
  logic [LEN_W-1:0]  gen1_pat_len   = 32'h0000_000d;
  logic [LEN_W-1:0]  gen2_pat_len   = 32'h0000_0007;
  logic              base_model     = 1'b0;
  logic              scope_track_on = 1'b0;
  scos_ref_t         ref_mode       = REF_INTERNAL;
  logic [LEN_W-1:0]  bit_rate_khz   = 32'h0013_12d0;
  logic [LEN_W-1:0]  ext_in_khz     = 32'h0009_8968;
  logic              clr            = 1'b0;
  scos_sel_t         sel_cur;
  logic              sel_err;
  logic              sync_out;
  logic              sync_active;
  logic              full_clk_out;
  logic              full_clk_en;
  logic [FREQ_W-1:0] full_freq_khz;
  logic [15:0]       sync_per;
  logic [15:0]       sync_cnt;
  logic [15:0]       fclk_cnt;
  logic [SEL_W-1:0]  exp_sel;
  logic              exp_en;
  logic [FREQ_W-1:0] exp_f;
  int                num_errors     = 0;
  int                checks         = 0;
  int                cyc            = 0;
  int                sp [4]         = '{1, 2, 3, 4};

  scos_top uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .sel_wr(sel_wr),
    .sel_code(sel_code), .gen1_div(gen1_div), .gen2_div(gen2_div), .det1_div(det1_div),
    .det2_div(det2_div), .gen1_bit_stb(stb[0]), .gen2_bit_stb(stb[1]), .det1_bit_stb(stb[2]),
    .det2_bit_stb(stb[3]), .gen1_pat_len(gen1_pat_len), .gen2_pat_len(gen2_pat_len),
    .base_model(base_model), .scope_track_on(scope_track_on), .ref_mode(ref_mode),
    .bit_rate_khz(bit_rate_khz), .ext_in_khz(ext_in_khz), .sel_cur(sel_cur),
    .sel_err(sel_err), .sync_out(sync_out), .sync_active(sync_active),
    .full_clk_out(full_clk_out), .full_clk_en(full_clk_en), .full_freq_khz(full_freq_khz));

  scos_scope_sink sink (.core_clk(core_clk), .clr(clr), .sync_out(sync_out),
    .full_clk_out(full_clk_out), .sync_per(sync_per), .sync_cnt(sync_cnt),
    .fclk_cnt(fclk_cnt));

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Bit strobes and timeout
  // ----------------------------------------------------------------
  // Each source strobes at its own spacing so a wrong source shows as a wrong period
  always @(negedge core_clk)
  begin
    cyc++;
    for (int k = 0; k < 4; k++)
      stb[k] <= (cyc % sp[k]) == 0;
    if (cyc >= 20000)
    begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [FREQ_W-1:0] got, input logic [FREQ_W-1:0] exp,
                     input string what);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Own view of which code is legal for the current divides
  function automatic logic legal_exp(input int code);
    int         d;
    logic [6:0] m;
    if (code >= 20)
      return 1'b0;
    d = (code < 7) ? gen1_div : (code < 14) ? gen2_div : (code < 17) ? det1_div : det2_div;
    if (code >= 14)
    begin
      m = (d == 0) ? 7'h06 : (d == 1) ? 7'h05 : 7'h00;
      return m[(code - 14) % 3];
    end
    if ((code % 7) == 6)
      return !(base_model && scope_track_on);
    m = (d == 0) ? 7'h78 : (d == 1) ? 7'h54 : (d == 2) ? 7'h52 : 7'h41;
    return m[code % 7];
  endfunction

  task automatic wr(input logic [SEL_W-1:0] code);
    logic ok;
    ok = legal_exp(int'(code)) && clk_en;
    @(negedge core_clk);
    sel_wr = 1'b1;
    sel_code = code;
    @(negedge core_clk);
    sel_wr = 1'b0;
    if (ok)
      exp_sel = code;
    chk(sel_cur, exp_sel, "selection");  // taken or kept
    chk(sel_err, !ok && clk_en, "refusal flag");  // refusal pulse
  endtask

  task automatic per(input logic [SEL_W-1:0] code, input int n, input int s);
    wr(code);
    wait_cyc(3 * n * s + 12);
    chk(sync_per, 40'(n * s), "sync period");  // source and ratio
    chk(sync_active, 1'b1, "sync active");  // held selection legal
  endtask

  task automatic pulse_clr();
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    exp_sel = SEL_G1_PAT;
    wait_cyc(5);
    rst_n = 1'b1;
    chk(sel_cur, SEL_G1_PAT, "reset selection");  // reset value
    chk(sync_out, 1'b0, "reset sync");  // quiet in reset
    for (int d = 0; d < 7; d++)
    begin
      gen1_div = scos_div_t'(d);
      gen2_div = scos_div_t'(6 - d);
      det1_div = scos_div_t'(d);
      det2_div = scos_div_t'((d + 1) % 7);
      for (int c = 0; c < 32; c++)
        wr(5'(c));  // every code at every divide
    end
    gen1_div = DIV_1;
    gen2_div = DIV_2;
    det1_div = DIV_1;
    det2_div = DIV_2;
    for (int b = 0; b < 3; b++)
    begin
      base_model = (b != 1);
      scope_track_on = (b != 2);
      wr(SEL_G1_D8);  // prior selection
      wr(SEL_G1_PAT);  // blocked only with both set
      wr(SEL_G2_PAT);  // blocked only with both set
    end
    clk_en = 1'b0;
    wr(SEL_G1_D16);  // frozen core ignores write
    clk_en = 1'b1;
    per(SEL_G1_D8, 8, 1);  // ratio 8
    per(SEL_G1_D64, 64, 1);  // ratio 64
    per(SEL_G1_PAT, 13, 1);  // pattern length
    per(SEL_G2_D4, 4, 2);  // channel 2
    per(SEL_G2_PAT, 7, 2);  // channel 2 pattern
    per(SEL_E1_D16, 16, 3);  // detector 1
    per(SEL_E2_D4, 4, 4);  // detector 2
    per(SEL_E1_D8, 8, 3);  // detector 1
    wr(SEL_G1_D64);  // legal at 1/1
    gen1_div = DIV_2;
    wait_cyc(4);
    pulse_clr();
    wait_cyc(80);
    chk(sync_active, 1'b0, "stale selection");  // illegal after divide change
    chk(sync_cnt, 0, "gated sync");  // no pulses while illegal
    for (int r = 0; r < 3; r++)
      for (int d = 0; d < 7; d++)
        for (int s = 0; s < 2; s++)
        begin
          ref_mode = scos_ref_t'(r);
          gen1_div = scos_div_t'(s ? 6 - d : d);
          gen2_div = scos_div_t'(s ? d : 6 - d);
          wr(s ? SEL_G2_PAT : SEL_G1_PAT);  // source set by sync write
          wait_cyc(3);
          pulse_clr();
          wait_cyc(24);
          exp_en = (d <= 3);
          exp_f = (r == 2) ? {8'h00, ext_in_khz} << 4 : {8'h00, bit_rate_khz};
          exp_f = exp_en ? exp_f << d : 40'h00_0000_0000;
          chk(full_clk_en, exp_en, "full clock enable");  // divide limit
          chk(full_freq_khz, exp_f, "full clock frequency");  // reference modes
          chk(fclk_cnt, exp_en ? 24 / (s + 1) : 0, "full clock pulses");  // source
        end
    finish_test();
  end
endmodule
`default_nettype wire
